//--- core/add_exec_map.svh
// register offsets, field positions, reset values and opcodes of the add executor
// assumes a 32-bit axi4-lite register bus with byte addresses below 8'h40
//
// Contract
// - a read-modify-write of the pin register reads the pin levels, not the output latch.
// - writing the timer zero count register also clears the prescaler when it is assigned.
// - an instruction that changes the program counter or takes a true test uses two cycles.
// - a stray second word of a two-word instruction decodes and runs as a no-operation.
// - add_literal_to_accum (0000 1111 kkkk kkkk) adds k to the accumulator, sets n/ov/c/dc/z.
// - add_literal_to_accum is one word and one four-phase cycle ending in the accumulator write.
// - with a=0, extended set on and f at most 95, the address is the index pointer plus f.
`ifndef ADD_EXEC_MAP_SVH
`define ADD_EXEC_MAP_SVH

`define REG_CTRL_OFS      8'h00
`define REG_STATUS_OFS    8'h04
`define REG_ACCUM_OFS     8'h08
`define REG_BANK_OFS      8'h0c
`define REG_PC_OFS        8'h10
`define REG_INDEX_OFS     8'h14
`define REG_TIMER_OFS     8'h18
`define REG_PROG_ADR_OFS  8'h1c
`define REG_PROG_DAT_OFS  8'h20
`define REG_DATA_ADR_OFS  8'h24
`define REG_DATA_DAT_OFS  8'h28

`define CTRL_RUN_BIT      0
`define CTRL_EXT_BIT      1
`define CTRL_PSA_BIT      2
`define CTRL_TMR_ON_BIT   3
`define CTRL_RESET        4'h0

`define FLAG_C_BIT        0
`define FLAG_DC_BIT       1
`define FLAG_Z_BIT        2
`define FLAG_OV_BIT       3
`define FLAG_N_BIT        4
`define STAT_BUSY_BIT     5

`define PIN_REG_ADDR      12'hf81
`define TIMER_REG_ADDR    12'hfd6
`define ACCESS_LIMIT      8'h5f
`define ACCESS_HIGH_BANK  4'hf

`define OPC_ADD_LIT       8'h0f
`define OPC_BZ            8'he0
`define OPC_GOTO          8'hef
`define OPC_ADD_FILE      6'h09
`define AXI_OKAY          2'b00
`define AXI_SLVERR        2'b10

`endif

//--- core/add_exec_pkg.sv
// types shared by the add executor
// assumes add_exec_map.svh supplies the numeric constants
package add_exec_pkg;

  typedef enum logic [2:0] {
    OP_NOP,
    OP_ADD_LIT,
    OP_ADD_FILE,
    OP_BZ,
    OP_GOTO
  } op_type;

  typedef enum logic [1:0] {
    PH_DECODE,
    PH_READ,
    PH_PROCESS,
    PH_WRITE
  } phase_type;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } flags_type;

  typedef struct packed {
    op_type     kind;
    logic       dest;
    logic       bank;
    logic [7:0] lit;
  } decoded_type;

endpackage

//--- core/add_instruction_exec.sv
// add_literal_to_accum / add_accum_to_file executor with local program and data memory
// assumes an axi4-lite master on the register bus and pins synchronous to core_clk_i
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "add_exec_map.svh"

module add_instruction_exec import add_exec_pkg::*; #(
  parameter int PROG_AW = 8,
  parameter int PS_W    = 8
) (
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         resetn_i,
  // axi4-lite write
  input  wire logic [7:0]   s_axi_awaddr_i,
  input  wire logic         s_axi_awvalid_i,
  output logic              s_axi_awready_o,
  input  wire logic [31:0]  s_axi_wdata_i,
  input  wire logic [3:0]   s_axi_wstrb_i,
  input  wire logic         s_axi_wvalid_i,
  output logic              s_axi_wready_o,
  output logic [1:0]        s_axi_bresp_o,
  output logic              s_axi_bvalid_o,
  input  wire logic         s_axi_bready_i,
  // axi4-lite read
  input  wire logic [7:0]   s_axi_araddr_i,
  input  wire logic         s_axi_arvalid_i,
  output logic              s_axi_arready_o,
  output logic [31:0]       s_axi_rdata_o,
  output logic [1:0]        s_axi_rresp_o,
  output logic              s_axi_rvalid_o,
  input  wire logic         s_axi_rready_i,
  // port pins
  input  wire logic [7:0]   pins_i,
  output logic [7:0]        pin_latch_o
);

  localparam int DATA_AW = 12;

  logic [15:0]        prog [2**PROG_AW];
  logic [7:0]         mem  [2**DATA_AW];
  logic [3:0]         ctrl;
  flags_type          flags;
  logic [7:0]         accum;
  logic [3:0]         bank_select_reg;
  logic [PROG_AW-1:0] pc;
  logic [DATA_AW-1:0] index_ptr;
  logic [7:0]         timer_zero_count;
  logic [PS_W-1:0]    prescaler;
  logic [PROG_AW-1:0] prog_adr;
  logic [DATA_AW-1:0] data_adr;
  phase_type          phase;
  logic [15:0]        instr;
  logic [15:0]        instr_next_word;
  logic               flush;
  decoded_type        dec;
  logic [DATA_AW-1:0] eff_adr;
  logic [7:0]         operand;
  logic [7:0]         result;
  flags_type          next_flags;
  flags_type          res_flags;
  logic               run;
  logic               exec_q4;

  assign run     = ctrl[`CTRL_RUN_BIT];
  assign exec_q4 = run && (phase == PH_WRITE);

  ////////////////////////////////////////////////////////////////////////////
  // decode and addressing

  always_comb begin
    dec      = '0;
    dec.kind = OP_NOP;
    dec.dest = instr[9];
    dec.bank = instr[8];
    dec.lit  = instr[7:0];
    case (instr[15:8])
      `OPC_ADD_LIT: dec.kind = OP_ADD_LIT;
      `OPC_BZ:      dec.kind = OP_BZ;
      `OPC_GOTO:    dec.kind = OP_GOTO;
      default: begin
        // a lone 1111 word and anything unknown fall through to a no-op
        if (instr[15:10] == `OPC_ADD_FILE) begin
          dec.kind = OP_ADD_FILE;
        end else begin
          dec.kind = OP_NOP;
        end
      end
    endcase
  end

  always_comb begin
    if (!dec.bank && ctrl[`CTRL_EXT_BIT] && (dec.lit <= `ACCESS_LIMIT)) begin
      eff_adr = index_ptr + {4'h0, dec.lit};
    end else if (!dec.bank) begin
      eff_adr = dec.lit[7] ? {`ACCESS_HIGH_BANK, dec.lit} : {4'h0, dec.lit};
    end else begin
      eff_adr = {bank_select_reg, dec.lit};
    end
  end

  function automatic logic [7:0] read_data(input logic [DATA_AW-1:0] adr);
    logic [7:0] val;
    val = mem[adr];
    if (adr == `PIN_REG_ADDR) begin
      val = pins_i;
    end else if (adr == `TIMER_REG_ADDR) begin
      val = timer_zero_count;
    end
    return val;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_adr;
  logic [31:0] w_dat;
  logic [3:0]  w_stb;
  logic        bus_wr;
  logic        wr_mapped;
  logic        rd_mapped;
  logic [31:0] rd_val;

  assign s_axi_awready_o = !aw_held;
  assign s_axi_wready_o  = !w_held;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign bus_wr          = aw_held && w_held && !s_axi_bvalid_o;

  always_comb begin
    case (aw_adr)
      `REG_CTRL_OFS, `REG_ACCUM_OFS, `REG_BANK_OFS, `REG_PC_OFS, `REG_INDEX_OFS,
      `REG_TIMER_OFS, `REG_PROG_ADR_OFS, `REG_PROG_DAT_OFS, `REG_DATA_ADR_OFS,
      `REG_DATA_DAT_OFS: wr_mapped = 1'b1;
      default:           wr_mapped = 1'b0;
    endcase
  end

  always_comb begin
    rd_mapped = 1'b1;
    rd_val    = '0;
    case (s_axi_araddr_i)
      `REG_CTRL_OFS:     rd_val[3:0] = ctrl;
      `REG_STATUS_OFS:   rd_val[5:0] = {run, flags};
      `REG_ACCUM_OFS:    rd_val[7:0] = accum;
      `REG_BANK_OFS:     rd_val[3:0] = bank_select_reg;
      `REG_PC_OFS:       rd_val[PROG_AW-1:0] = pc;
      `REG_INDEX_OFS:    rd_val[DATA_AW-1:0] = index_ptr;
      `REG_TIMER_OFS:    rd_val[7:0] = timer_zero_count;
      `REG_PROG_ADR_OFS: rd_val[PROG_AW-1:0] = prog_adr;
      `REG_PROG_DAT_OFS: rd_val[15:0] = prog[prog_adr];
      `REG_DATA_ADR_OFS: rd_val[DATA_AW-1:0] = data_adr;
      `REG_DATA_DAT_OFS: rd_val[7:0] = read_data(data_adr);
      default:           rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_held <= 1'b0;
      aw_adr  <= 8'h00;
    end else if (s_axi_awvalid_i && !aw_held) begin
      aw_held <= 1'b1;
      aw_adr  <= s_axi_awaddr_i;
    end else if (bus_wr) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      w_held <= 1'b0;
      w_dat  <= 32'h0000_0000;
      w_stb  <= 4'h0;
    end else if (s_axi_wvalid_i && !w_held) begin
      w_held <= 1'b1;
      w_dat  <= s_axi_wdata_i;
      w_stb  <= s_axi_wstrb_i;
    end else if (bus_wr) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `AXI_OKAY;
    end else if (bus_wr) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_mapped ? `AXI_OKAY : `AXI_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= `AXI_OKAY;
    end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= rd_val;
      s_axi_rresp_o  <= rd_mapped ? `AXI_OKAY : `AXI_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  function automatic logic bus_hit(input logic [7:0] ofs);
    return bus_wr && (aw_adr == ofs) && w_stb[0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // software-owned registers

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl      <= `CTRL_RESET;
      index_ptr <= '0;
      prog_adr  <= '0;
      data_adr  <= '0;
    end else begin
      if (bus_hit(`REG_CTRL_OFS)) ctrl <= w_dat[3:0];
      if (bus_hit(`REG_INDEX_OFS)) index_ptr <= w_dat[DATA_AW-1:0];
      if (bus_hit(`REG_DATA_ADR_OFS)) data_adr <= w_dat[DATA_AW-1:0];
      if (bus_hit(`REG_PROG_ADR_OFS)) begin
        prog_adr <= w_dat[PROG_AW-1:0];
      end else if (bus_hit(`REG_PROG_DAT_OFS)) begin
        prog_adr <= prog_adr + PROG_AW'(1);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (bus_wr && (aw_adr == `REG_PROG_DAT_OFS) && (w_stb[1:0] == 2'b11)) begin
      prog[prog_adr] <= w_dat[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // four-phase sequencer

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase <= PH_DECODE;
    end else if (!run) begin
      phase <= PH_DECODE;
    end else begin
      case (phase)
        PH_DECODE:  phase <= PH_READ;
        PH_READ:    phase <= PH_PROCESS;
        PH_PROCESS: phase <= PH_WRITE;
        PH_WRITE:   phase <= PH_DECODE;
        default:    phase <= PH_DECODE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      instr           <= 16'h0000;
      instr_next_word <= 16'h0000;
    end else if (run && (phase == PH_DECODE)) begin
      // a flushed cycle runs an all-zero word, which is the no-op
      instr           <= flush ? 16'h0000 : prog[pc];
      instr_next_word <= prog[pc + PROG_AW'(1)];
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      operand <= 8'h00;
    end else if (run && (phase == PH_READ)) begin
      operand <= (dec.kind == OP_ADD_LIT) ? dec.lit : read_data(eff_adr);
    end
  end

  always_comb begin
    logic [8:0] sum;
    logic [4:0] low;
    sum          = {1'b0, accum} + {1'b0, operand};
    low          = {1'b0, accum[3:0]} + {1'b0, operand[3:0]};
    next_flags.c  = sum[8];
    next_flags.dc = low[4];
    next_flags.z  = (sum[7:0] == 8'h00);
    next_flags.n  = sum[7];
    next_flags.ov = (accum[7] == operand[7]) && (sum[7] != accum[7]);
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result    <= 8'h00;
      res_flags <= '0;
    end else if (run && (phase == PH_PROCESS)) begin
      result    <= accum + operand;
      res_flags <= next_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write-back, program counter and flush

  logic               take_branch;
  logic               skip_second;
  logic               file_wr;
  logic [PROG_AW-1:0] goto_target;
  logic [19:0]        goto_k;

  assign goto_k      = {instr_next_word[11:0], dec.lit};
  assign goto_target = goto_k[PROG_AW-1:0];
  assign take_branch = (dec.kind == OP_GOTO) || ((dec.kind == OP_BZ) && flags.z);
  assign skip_second = (dec.kind == OP_GOTO);
  assign file_wr     = exec_q4 && (dec.kind == OP_ADD_FILE) && dec.dest;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pc    <= '0;
      flush <= 1'b0;
    end else if (exec_q4) begin
      flush <= take_branch && !flush;
      if (flush) begin
        pc <= pc;
      end else if (dec.kind == OP_GOTO) begin
        pc <= goto_target;
      end else if (take_branch) begin
        pc <= pc + PROG_AW'(1) + PROG_AW'($signed(dec.lit));
      end else begin
        pc <= pc + PROG_AW'(1);
      end
    end else if (!run && bus_hit(`REG_PC_OFS)) begin
      pc    <= w_dat[PROG_AW-1:0];
      flush <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      accum <= 8'h00;
      flags <= '0;
    end else if (exec_q4 && ((dec.kind == OP_ADD_LIT) || (dec.kind == OP_ADD_FILE))) begin
      flags <= res_flags;
      if ((dec.kind == OP_ADD_LIT) || !dec.dest) begin
        accum <= result;
      end
    end else if (bus_hit(`REG_ACCUM_OFS)) begin
      accum <= w_dat[7:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bank_select_reg <= 4'h0;
    end else if (bus_hit(`REG_BANK_OFS)) begin
      bank_select_reg <= w_dat[3:0];
    end
  end

  // one data write port: the instruction wins over the bus in the same cycle
  logic               dw_en;
  logic [DATA_AW-1:0] dw_adr;
  logic [7:0]         dw_val;

  assign dw_en  = file_wr || bus_hit(`REG_DATA_DAT_OFS);
  assign dw_adr = file_wr ? eff_adr : data_adr;
  assign dw_val = file_wr ? result : w_dat[7:0];

  always_ff @(posedge core_clk_i) begin
    if (dw_en) begin
      mem[dw_adr] <= dw_val;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_latch_o <= 8'h00;
    end else if (dw_en && (dw_adr == `PIN_REG_ADDR)) begin
      pin_latch_o <= dw_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer zero and its prescaler

  logic timer_wr;
  logic ps_tick;

  assign timer_wr = (dw_en && (dw_adr == `TIMER_REG_ADDR)) || bus_hit(`REG_TIMER_OFS);
  assign ps_tick  = ctrl[`CTRL_PSA_BIT] ? (&prescaler) : 1'b1;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prescaler <= '0;
    end else if (timer_wr && ctrl[`CTRL_PSA_BIT]) begin
      prescaler <= '0;
    end else if (ctrl[`CTRL_TMR_ON_BIT]) begin
      prescaler <= prescaler + PS_W'(1);
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timer_zero_count <= 8'h00;
    end else if (timer_wr) begin
      timer_zero_count <= bus_hit(`REG_TIMER_OFS) && !dw_en ? w_dat[7:0] : dw_val;
    end else if (ctrl[`CTRL_TMR_ON_BIT] && ps_tick) begin
      timer_zero_count <= timer_zero_count + 8'h01;
    end
  end

endmodule

//--- testbench/add_exec_monitor.sv
// concurrent checks on the register bus handshakes of the add executor
// assumes it is bound into add_instruction_exec and sees only that module's ports
`timescale 1ns/1ps

module add_exec_monitor #(
  parameter int PROG_AW = 8,
  parameter int PS_W    = 8
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  // write side
  input  wire logic        s_axi_awvalid_i,
  input  wire logic        s_axi_awready_o,
  input  wire logic        s_axi_wvalid_i,
  input  wire logic        s_axi_wready_o,
  input  wire logic [1:0]  s_axi_bresp_o,
  input  wire logic        s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // read side
  input  wire logic        s_axi_arvalid_i,
  input  wire logic        s_axi_arready_o,
  input  wire logic [31:0] s_axi_rdata_o,
  input  wire logic [1:0]  s_axi_rresp_o,
  input  wire logic        s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o && !s_axi_bvalid_o;
  endsequence
  sequence s_wr_answer;
    !s_axi_bvalid_o ##1 s_axi_bvalid_o;
  endsequence

  property p_wr_answer;
    s_wr_taken |=> s_wr_answer;
  endproperty
  property p_aw_held;
    s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o;
  endproperty
  property p_w_held;
    s_axi_wvalid_i && s_axi_wready_o |=> !s_axi_wready_o;
  endproperty
  property p_b_stands;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  property p_b_done;
    s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o;
  endproperty
  property p_rd_answer;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o;
  endproperty
  property p_r_stands;
    s_axi_rvalid_o && !s_axi_rready_i |=>
      s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o);
  endproperty
  property p_r_done;
    s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o;
  endproperty

  a_wr_answer: assert property (p_wr_answer) else $error("write answer not two cycles later");
  a_aw_held: assert property (p_aw_held) else $error("write address accepted twice");
  a_w_held: assert property (p_w_held) else $error("write data accepted twice");
  a_b_stands: assert property (p_b_stands) else $error("write response not held");
  a_b_done: assert property (p_b_done) else $error("write response not released");
  a_rd_answer: assert property (p_rd_answer) else $error("read answer not one cycle later");
  a_r_stands: assert property (p_r_stands) else $error("read data not held");
  a_r_done: assert property (p_r_done) else $error("read data not released");
endmodule

bind add_instruction_exec add_exec_monitor #(.PROG_AW(PROG_AW), .PS_W(PS_W)) mon_u (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i)
);

//--- testbench/tb_top.sv
// self-checking bench: bus tasks load programs, run them and read back results
// assumes the package, the map header and the bound monitor are compiled beforehand
`timescale 1ns/1ps
`include "add_exec_map.svh"

module tb_top import add_exec_pkg::*;;
  logic        core_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00, pins_i = 8'h05;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0]  s_axi_wstrb_i = 4'hf;
  logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic [7:0]  pin_latch_o;
  int          n_mismatch = 0;
  int          check_count = 0;
  localparam logic [15:0] PROG [24] = '{
    16'hf123, 16'h0f7f, 16'h0f01, 16'hef03, 16'hf000, 16'h0000, 16'h0000, 16'h0000,
    16'h0f80, 16'he001, 16'h0f55, 16'hef0b, 16'hf000, 16'h0000, 16'h0000, 16'h0000,
    16'h0f11, 16'h2730, 16'h2410, 16'h2460, 16'h2681, 16'h26d6, 16'hef16, 16'hf000};

  always #5 core_clk_i = ~core_clk_i;

  add_instruction_exec #(.PROG_AW(8), .PS_W(2)) dut_u (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wdata_i(s_axi_wdata_i), .s_axi_wstrb_i(s_axi_wstrb_i),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
    .pins_i(pins_i), .pin_latch_o(pin_latch_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic stuck;
    n_mismatch++;
    $display("wrong value at %0t: bus or program wait ran out", $time);
    conclude();
  endtask

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: data %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: response %b, expected %b", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // a slow call raises the response ready only some cycles after the request
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = `AXI_OKAY, input bit slow = 1'b0);
    int n;
    @(posedge core_clk_i);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= !slow;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (n == 3 && !s_axi_bready_i) s_axi_bready_i <= 1'b1;
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bready_i <= 1'b0;
        chk_resp(s_axi_bresp_o, er);
        return;
      end
    end
    stuck();
  endtask

  task automatic rd_raw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
                        input bit slow = 1'b0);
    int n;
    @(posedge core_clk_i);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= !slow;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (n == 3 && !s_axi_rready_i) s_axi_rready_i <= 1'b1;
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
        return;
      end
    end
    stuck();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er = `AXI_OKAY, input bit slow = 1'b0);
    logic [31:0] d;
    logic [1:0]  r;
    rd_raw(a, d, r, slow);
    chk_data(d, exp);
    chk_resp(r, er);
  endtask

  task automatic wdat(input logic [11:0] a, input logic [7:0] b);
    wr(`REG_DATA_ADR_OFS, {20'h0, a});
    wr(`REG_DATA_DAT_OFS, {24'h0, b});
  endtask

  task automatic rdat(input logic [11:0] a, input logic [7:0] exp);
    wr(`REG_DATA_ADR_OFS, {20'h0, a});
    rd(`REG_DATA_DAT_OFS, {24'h0, exp});
  endtask

  // starts at one address and stops once the program parks on its closing jump
  task automatic run(input logic [7:0] start, input logic [7:0] halt, input logic [31:0] mode);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    wr(`REG_PC_OFS, {24'h0, start});
    wr(`REG_CTRL_OFS, mode | 32'h1);
    for (n = 0; n < 40; n++) begin
      rd_raw(`REG_PC_OFS, d, r);
      if (d === {24'h0, halt}) break;
    end
    if (n == 40) stuck();
    wr(`REG_CTRL_OFS, mode);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    rd(`REG_ACCUM_OFS, 32'h0);
    rd(`REG_CTRL_OFS, 32'h0);
    wr(8'h3c, 32'h1, `AXI_SLVERR, 1'b1);
    rd(8'h3c, 32'h0, `AXI_SLVERR, 1'b1);
    wr(`REG_PROG_ADR_OFS, 32'h0);
    foreach (PROG[i]) wr(`REG_PROG_DAT_OFS, {16'h0, PROG[i]});
    run(8'h00, 8'h03, 32'h0);
    rd(`REG_ACCUM_OFS, 32'h80);
    rd(`REG_STATUS_OFS, 32'h1a, `AXI_OKAY, 1'b1);
    run(8'h08, 8'h0b, 32'h0);
    rd(`REG_ACCUM_OFS, 32'h00);
    rd(`REG_STATUS_OFS, 32'h0d);
    wdat(12'h230, 8'h22);
    wdat(12'h310, 8'h40);
    wdat(12'h060, 8'h08);
    wdat(12'hf81, 8'hff);
    chk_data({24'h0, pin_latch_o}, 32'hff);
    wr(`REG_BANK_OFS, 32'h2);
    wr(`REG_INDEX_OFS, 32'h300);
    run(8'h10, 8'h16, 32'h2);
    rd(`REG_ACCUM_OFS, 32'h59);
    rdat(12'h230, 8'h33);
    chk_data({24'h0, pin_latch_o}, 32'h5e);
    rdat(12'hf81, 8'h05);
    rd(`REG_TIMER_OFS, 32'h59);
    // prescaler on at ratio four: the read in between leaves the free count at two
    wr(`REG_CTRL_OFS, 32'hc);
    rd(`REG_CTRL_OFS, 32'hc);
    wr(`REG_TIMER_OFS, 32'h40);
    rd(`REG_TIMER_OFS, 32'h40);
    rd(`REG_TIMER_OFS, 32'h41);
    rd(`REG_TIMER_OFS, 32'h42);
    wr(`REG_CTRL_OFS, 32'h0);
    conclude();
  end
endmodule
